// ==== hw/tlv_header_decoder.sv ====
/*
 * byte-serial tag/length header decoder with template tracking.
 * assumes bytes arrive high order first under valid/ready, and an
 * axi4-lite master for control and status.
 */
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps

// Overview of operation
// - tag fields of one or two bytes are accepted
// - length fields of one to three bytes accepted, longer ones unsupported
// - zero length ends the object at once, next byte is a tag
// - class comes from the two top bits of the first tag byte
// - bit five of the first tag byte marks constructed, else primitive
// - low five bits: tag number; all ones continues, all zeros invalid
// - subsequent tag byte: low seven bits number, top bit means more
// - tags 61 and 6F are iso templates and constructed containers
// - tags 70 to 7F are payment application templates
// - primitive 80-9E and 9F01-9F4F are specification reserved
// - primitive 9F50-9F7F are reserved for the payment systems
// - private class objects pass through as issuer defined
// - context tags are resolved against the enclosing open template
// - inside template 76 context tags are not ordinary data elements
// - 9F38 is the processing options object list, allowed in A5
// - A5 nests in 6F; BF0C is accepted nested inside A5
// - 9D is the directory definition file name, valid only inside 61
// - length byte top bit clear: length; set: count of further bytes
module tlv_header_decoder
    import tlv_pkg::*;
#(
    parameter int NEST_DEPTH = 4
)
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // byte stream
    input wire logic byte_valid_i,
    input wire logic [7:0] byte_data_i,
    output logic byte_ready_o,
    // header event
    output logic hdr_valid_o,
    output logic [15:0] hdr_tag_o,
    output logic [15:0] hdr_len_o,
    output logic [3:0] hdr_kind_o,
    output logic hdr_err_o,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ------------------------------------------------------------
    // reset release and stack
    // ------------------------------------------------------------
    logic [1:0] rst_sync;
    logic rst_b;

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rst_sync <= 2'b00;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_b = rst_sync[1];

    tlv_nest_if #(.DEPTH(NEST_DEPTH)) nest ();

    tlv_stack #(.DEPTH(NEST_DEPTH)) u_stack (
        .clk_i(sys_clk_i),
        .rst_b_i(rst_b),
        .nest(nest)
    );

    // ------------------------------------------------------------
    // classification
    // ------------------------------------------------------------
    function automatic logic in_range(input logic [15:0] t, input logic [15:0] lo, input logic [15:0] hi);
        in_range = (t >= lo) && (t <= hi);
    endfunction

    function automatic tag_kind_e classify(input logic [15:0] t, input logic [15:0] parent, input logic cons);
        logic [7:0] first;
        first = (t[15:8] != 8'h00) ? t[15:8] : t[7:0];
        classify = KIND_OTHER;
        if (first[7:6] == 2'b11)
            classify = KIND_ISSUER;
        else if (t == TAG_APP_TMPL || t == TAG_FCI_TMPL)
            classify = KIND_ISO_TMPL;
        else if (in_range(t, TAG_PAY_LO, TAG_PAY_HI))
            classify = KIND_PAY_TMPL;
        else if (first[7:6] == 2'b10 && parent == TAG_FUNC_TMPL)
            classify = KIND_FUNC_OBJ;
        else if (t == TAG_FCI_PROP)
            classify = (parent == TAG_FCI_TMPL) ? KIND_FCI_PROP : KIND_MISPLACED;
        else if (t == TAG_FCI_ISSUER)
            classify = (parent == TAG_FCI_PROP) ? KIND_FCI_ISSUER : KIND_MISPLACED;
        else if (t == TAG_POOL)
            classify = (parent == TAG_FCI_PROP) ? KIND_POOL : KIND_MISPLACED;
        else if (t == TAG_DDF_NAME)
            classify = (parent == TAG_APP_TMPL) ? KIND_DDF_NAME : KIND_MISPLACED;
        else if (!cons && (in_range(t, TAG_SPEC1_LO, TAG_SPEC1_HI) || in_range(t, TAG_SPEC2_LO, TAG_SPEC2_HI)))
            classify = KIND_SPEC_RSVD;
        else if (!cons && in_range(t, TAG_PAYSYS_LO, TAG_PAYSYS_HI))
            classify = KIND_PAYSYS_RSVD;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        dec_state_e st;
        logic [15:0] tag;
        logic cons;
        logic [1:0] cls;
        logic [6:0] tag_num;
        logic [1:0] len_extra;
        logic [15:0] len;
        logic [15:0] vleft;
        logic hdr_valid;
        logic [15:0] hdr_tag;
        logic [15:0] hdr_len;
        logic [3:0] hdr_kind;
        logic err;
        logic [31:0] ctrl;
        logic [15:0] count;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic ready;
    } dec_s;

    dec_s cur;
    dec_s next_cur;
    logic take;
    logic enable;
    logic clr;
    logic [7:0] b;

    assign enable = cur.ctrl[CTRL_ENABLE_BIT];
    assign take = byte_valid_i && cur.ready;
    assign b = byte_data_i;

    always_comb
    begin
        next_cur = cur;
        next_cur.hdr_valid = 1'b0;
        nest.push = 1'b0;
        nest.pop = 1'b0;
        nest.push_tag = cur.tag;
        nest.push_left = cur.len;
        nest.tick = 1'b0;
        clr = 1'b0;

        // ---------------- byte decode
        if (take)
        begin
            nest.tick = (cur.st != ST_TAG1 || !nest.empty);
            unique case (cur.st)
                ST_TAG1:
                begin
                    next_cur.tag = {8'h00, b};
                    next_cur.cls = b[7:6];
                    next_cur.cons = b[TAG_CONS_BIT];
                    next_cur.tag_num = {2'b00, b[4:0]};
                    next_cur.len = 16'h0000;
                    next_cur.len_extra = 2'b00;
                    if (b[4:0] == TAG_NUM_UNUSED)
                        next_cur.err = 1'b1;
                    else if (b[4:0] == TAG_NUM_MORE)
                        next_cur.st = ST_TAG2;
                    else
                        next_cur.st = ST_LEN1;
                end
                ST_TAG2:
                begin
                    next_cur.tag = {cur.tag[7:0], b};
                    next_cur.tag_num = b[6:0];
                    if (b[TAG_MORE_BIT])
                    begin
                        next_cur.err = 1'b1;
                        next_cur.st = ST_TAG1;
                    end
                    else
                        next_cur.st = ST_LEN1;
                end
                ST_LEN1:
                begin
                    if (!b[LEN_LONG_BIT])
                        next_cur.len = {9'h000, b[6:0]};
                    else if (b[6:0] == 7'h00 || b[6:0] > LEN_MAX_EXTRA)
                        next_cur.err = 1'b1;
                    else
                        next_cur.len_extra = b[1:0];
                    if (!b[LEN_LONG_BIT] || next_cur.err)
                        next_cur.st = ST_VALUE;
                    else
                        next_cur.st = ST_LENX;
                end
                ST_LENX:
                begin
                    next_cur.len = {cur.len[7:0], b};
                    next_cur.len_extra = cur.len_extra - 2'b01;
                    if (cur.len_extra == 2'b01)
                        next_cur.st = ST_VALUE;
                end
                ST_VALUE:
                begin
                    next_cur.vleft = cur.vleft - 16'h0001;
                    if (cur.vleft == 16'h0001)
                        next_cur.st = ST_TAG1;
                end
                default:
                    next_cur.st = ST_TAG1;
            endcase
        end

        // ---------------- header complete
        if (take && next_cur.st == ST_VALUE && cur.st != ST_VALUE)
        begin
            next_cur.hdr_valid = 1'b1;
            next_cur.hdr_tag = cur.tag;
            next_cur.hdr_len = next_cur.len;
            next_cur.hdr_kind = classify(cur.tag, nest.top_tag, cur.cons);
            next_cur.count = cur.count + 16'h0001;
            next_cur.vleft = next_cur.len;
            if (next_cur.err)
                next_cur.st = ST_TAG1;
            else if (next_cur.len == 16'h0000)
                next_cur.st = ST_TAG1;
            else if (cur.cons && !nest.full)
            begin
                // containers are opened, not skipped; body bytes are tags
                nest.push = 1'b1;
                nest.push_left = next_cur.len;
                next_cur.st = ST_TAG1;
            end
        end
        else if (!nest.empty && nest.top_left == 16'h0000)
            nest.pop = 1'b1;

        // ---------------- register writes
        if (s_axi_awvalid && !cur.aw_got)
        begin
            next_cur.aw_got = 1'b1;
            next_cur.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !cur.w_got)
        begin
            next_cur.w_got = 1'b1;
            next_cur.wdata = s_axi_wdata;
            next_cur.wstrb = s_axi_wstrb;
        end
        if (cur.aw_got && cur.w_got && !cur.bvalid)
        begin
            next_cur.aw_got = 1'b0;
            next_cur.w_got = 1'b0;
            next_cur.bvalid = 1'b1;
            next_cur.bresp = RESP_OKAY;
            if (cur.awaddr == CTRL_ADDR)
            begin
                if (cur.wstrb[0])
                    next_cur.ctrl[7:0] = cur.wdata[7:0];
                clr = cur.wstrb[0] && cur.wdata[CTRL_CLEAR_BIT];
                next_cur.ctrl[CTRL_CLEAR_BIT] = 1'b0;
            end
            else if (cur.awaddr != STATUS_ADDR)
                next_cur.bresp = RESP_SLVERR;
        end
        if (cur.bvalid && s_axi_bready)
            next_cur.bvalid = 1'b0;
        // error clear loses to a new error in the same cycle
        if (clr && !(take && next_cur.err && !cur.err))
            next_cur.err = 1'b0;

        // ---------------- register reads
        if (s_axi_arvalid && !cur.rvalid)
        begin
            next_cur.rvalid = 1'b1;
            next_cur.rresp = RESP_OKAY;
            unique case (s_axi_araddr)
                CTRL_ADDR: next_cur.rdata = cur.ctrl;
                STATUS_ADDR: next_cur.rdata = {24'h0, 4'(nest.level), cur.st, cur.err};
                TAG_ADDR: next_cur.rdata = {16'h0, cur.hdr_tag};
                LEN_ADDR: next_cur.rdata = {16'h0, cur.hdr_len};
                CLASS_ADDR: next_cur.rdata = {18'h0, cur.hdr_kind, cur.tag_num, cur.cons, cur.cls};
                COUNT_ADDR: next_cur.rdata = {16'h0, cur.count};
                default:
                begin
                    next_cur.rdata = 32'h0000_0000;
                    next_cur.rresp = RESP_SLVERR;
                end
            endcase
        end
        else if (cur.rvalid && s_axi_rready)
            next_cur.rvalid = 1'b0;

        // stall while disabled or in error, and one cycle after each header (and push) or pop
        next_cur.ready = enable && !next_cur.err && !nest.push && !nest.pop && !next_cur.hdr_valid;
    end

    always_ff @(posedge sys_clk_i or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cur <= '0;
            cur.st <= ST_TAG1;
            cur.ctrl <= CTRL_RESET;
        end
        else
            cur <= next_cur;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign byte_ready_o = cur.ready;
    assign hdr_valid_o = cur.hdr_valid;
    assign hdr_tag_o = cur.hdr_tag;
    assign hdr_len_o = cur.hdr_len;
    assign hdr_kind_o = cur.hdr_kind;
    assign hdr_err_o = cur.err;
    assign s_axi_awready = !cur.aw_got;
    assign s_axi_wready = !cur.w_got;
    assign s_axi_bvalid = cur.bvalid;
    assign s_axi_bresp = cur.bresp;
    assign s_axi_arready = !cur.rvalid;
    assign s_axi_rvalid = cur.rvalid;
    assign s_axi_rdata = cur.rdata;
    assign s_axi_rresp = cur.rresp;
endmodule

// ==== hw/tlv_nest_if.sv ====
/*
 * carrier between the decoder and its template stack.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface tlv_nest_if #(parameter int DEPTH = 4);
    logic push;
    logic pop;
    logic [15:0] push_tag;
    logic [15:0] push_left;
    logic [15:0] top_tag;
    logic [15:0] top_left;
    logic tick;
    logic full;
    logic empty;
    logic [$clog2(DEPTH+1)-1:0] level;

    modport dec (output push, pop, push_tag, push_left, tick, input top_tag, top_left, full, empty, level);
    modport stk (input push, pop, push_tag, push_left, tick, output top_tag, top_left, full, empty, level);
endinterface

// ==== hw/tlv_pkg.sv ====
/*
 * shared constants and types for the tag/length header decoder.
 * assumes a single clock domain and an axi4-lite register master.
 */
package tlv_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam logic [7:0] TAG_ADDR = 8'h08;
    localparam logic [7:0] LEN_ADDR = 8'h0C;
    localparam logic [7:0] CLASS_ADDR = 8'h10;
    localparam logic [7:0] COUNT_ADDR = 8'h14;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_CLEAR_BIT = 1;
    localparam int TAG_MORE_BIT = 7;
    localparam int TAG_CONS_BIT = 5;
    localparam int LEN_LONG_BIT = 7;
    localparam logic [4:0] TAG_NUM_MORE = 5'h1F;
    localparam logic [4:0] TAG_NUM_UNUSED = 5'h00;
    localparam logic [6:0] LEN_MAX_EXTRA = 7'h02;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // tag values and classes
    // ------------------------------------------------------------
    localparam logic [15:0] TAG_APP_TMPL = 16'h0061;
    localparam logic [15:0] TAG_FCI_TMPL = 16'h006F;
    localparam logic [15:0] TAG_PAY_LO = 16'h0070;
    localparam logic [15:0] TAG_PAY_HI = 16'h007F;
    localparam logic [15:0] TAG_FUNC_TMPL = 16'h0076;
    localparam logic [15:0] TAG_SPEC1_LO = 16'h0080;
    localparam logic [15:0] TAG_SPEC1_HI = 16'h009E;
    localparam logic [15:0] TAG_SPEC2_LO = 16'h9F01;
    localparam logic [15:0] TAG_SPEC2_HI = 16'h9F4F;
    localparam logic [15:0] TAG_PAYSYS_LO = 16'h9F50;
    localparam logic [15:0] TAG_PAYSYS_HI = 16'h9F7F;
    localparam logic [15:0] TAG_DDF_NAME = 16'h009D;
    localparam logic [15:0] TAG_POOL = 16'h9F38;
    localparam logic [15:0] TAG_FCI_PROP = 16'h00A5;
    localparam logic [15:0] TAG_FCI_ISSUER = 16'hBF0C;

    typedef enum logic [3:0] {
        KIND_OTHER = 4'h0,
        KIND_ISO_TMPL = 4'h1,
        KIND_PAY_TMPL = 4'h2,
        KIND_SPEC_RSVD = 4'h3,
        KIND_PAYSYS_RSVD = 4'h4,
        KIND_ISSUER = 4'h5,
        KIND_FUNC_OBJ = 4'h6,
        KIND_POOL = 4'h7,
        KIND_FCI_PROP = 4'h8,
        KIND_FCI_ISSUER = 4'h9,
        KIND_DDF_NAME = 4'hA,
        KIND_MISPLACED = 4'hB
    } tag_kind_e;

    typedef enum logic [2:0] {
        ST_TAG1 = 3'b000,
        ST_TAG2 = 3'b001,
        ST_LEN1 = 3'b011,
        ST_LENX = 3'b010,
        ST_VALUE = 3'b110
    } dec_state_e;

endpackage

// ==== hw/tlv_stack.sv ====
/*
 * template stack: open container tags and their remaining byte counts.
 * assumes the decoder never pushes when full nor pops when empty.
 */
`timescale 1ns/1ps
module tlv_stack
    import tlv_pkg::*;
#(
    parameter int DEPTH = 4
)
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    tlv_nest_if.stk nest
);
    // status reports the level in four bits
    if (DEPTH < 1 || DEPTH > 15)
    begin
        $error("tlv_stack: DEPTH out of range");
    end

    typedef struct packed {
        logic [DEPTH-1:0][15:0] tag;
        logic [DEPTH-1:0][15:0] left;
        logic [$clog2(DEPTH+1)-1:0] level;
        logic [15:0] top_tag;
        logic [15:0] top_left;
    } stack_s;

    stack_s cur;
    stack_s next_cur;

    always_comb
    begin
        next_cur = cur;
        // every byte of a template body counts down all open levels
        if (nest.tick)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                if (i < int'(cur.level) && cur.left[i] != 16'h0000)
                    next_cur.left[i] = cur.left[i] - 16'h0001;
            end
        end
        if (nest.pop && cur.level != '0)
            next_cur.level = cur.level - 1'b1;
        else if (nest.push && int'(cur.level) < DEPTH)
        begin
            next_cur.tag[cur.level] = nest.push_tag;
            next_cur.left[cur.level] = nest.push_left;
            next_cur.level = cur.level + 1'b1;
        end
        // registered view of the innermost level
        if (next_cur.level == '0)
        begin
            next_cur.top_tag = 16'h0000;
            next_cur.top_left = 16'h0000;
        end
        else
        begin
            next_cur.top_tag = next_cur.tag[next_cur.level - 1'b1];
            next_cur.top_left = next_cur.left[next_cur.level - 1'b1];
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            cur <= '0;
        else
            cur <= next_cur;
    end

    assign nest.top_tag = cur.top_tag;
    assign nest.top_left = cur.top_left;
    assign nest.level = cur.level;
    assign nest.full = (int'(cur.level) == DEPTH);
    assign nest.empty = (cur.level == '0);
endmodule

// ==== sim/ber_tlv_tag_decoder_bench.sv ====
/* self-checking bench for the tag/length header decoder.
   assumes byte_source feeds the stream; the bench is the register master. */
`timescale 1ns/1ps
module ber_tlv_tag_decoder_bench
    import tlv_pkg::*;
;
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic byte_valid_i, byte_ready_o, hdr_valid_o, hdr_err_o;
    logic [7:0] byte_data_i;
    logic [15:0] hdr_tag_o, hdr_len_o;
    logic [3:0] hdr_kind_o;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [35:0] hq[$];
    logic [35:0] hx[16] = '{36'h006F000B1, 36'h00A500098, 36'h9F3800017, 36'hBF0C00029, 36'h009D0000B, 36'h006100031,
        36'h009D0001A, 36'h007000032, 36'h9F5000004, 36'h9F0100023, 36'h009E00003, 36'h9F7F00004, 36'h007600032,
        36'h008100016, 36'h00C100005, 36'h00E200005};
    logic [15:0] ex[3] = '{16'h0040, 16'h9F81, 16'h5A83};
    int fails = 0;
    int n_tests = 0;
    always #2 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) if (hdr_valid_o === 1'b1) hq.push_back({hdr_tag_o, hdr_len_o, hdr_kind_o});
    tlv_header_decoder #(.NEST_DEPTH(4)) uut (.sys_clk_i, .rst_b_i, .byte_valid_i, .byte_data_i, .byte_ready_o,
        .hdr_valid_o, .hdr_tag_o, .hdr_len_o, .hdr_kind_o, .hdr_err_o, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    byte_source src (.clk_i(sys_clk_i), .rst_b_i, .ready_i(byte_ready_o), .valid_o(byte_valid_i),
        .data_o(byte_data_i));
    task automatic cmp_val(input logic [35:0] got, input logic [35:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // headers are logged as they pulse; wait bounded for the next one
    task automatic cmp_hdr(input logic [35:0] exp);
        logic [35:0] got = 36'hX;
        for (int k = 0; k < 400 && hq.size() == 0; k++) @(posedge sys_clk_i);
        if (hq.size() > 0) got = hq.pop_front();
        cmp_val(got, exp);
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
        @(posedge sys_clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        repeat (200)
        begin
            @(posedge sys_clk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        cmp_val({33'h0, s_axi_bvalid, s_axi_bresp}, {33'h0, 1'b1, resp});
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] resp);
        @(posedge sys_clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        repeat (200)
        begin
            @(posedge sys_clk_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        cmp_val({1'b0, s_axi_rvalid, s_axi_rresp, s_axi_rdata}, {1'b0, 1'b1, resp, exp});
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        chk_rd(CTRL_ADDR, CTRL_RESET, RESP_OKAY);
        chk_rd(STATUS_ADDR, 32'h0, RESP_OKAY);
        chk_rd(8'h40, 32'h0, RESP_SLVERR);
        axi_write(8'h40, 32'h0, RESP_SLVERR);
        // decoder held off while a stalling source queues nested objects
        axi_write(CTRL_ADDR, 32'h0, RESP_OKAY);
        repeat (2) @(posedge sys_clk_i);
        src.gap = 1;
        src.q = {8'h6F, 8'h0B, 8'hA5, 8'h09, 8'h9F, 8'h38, 8'h01, 8'hAA, 8'hBF, 8'h0C, 8'h02, 8'h9D, 8'h00,
            8'h61, 8'h03, 8'h9D, 8'h01, 8'h55, 8'h70, 8'h81, 8'h03, 8'h9F, 8'h50, 8'h00, 8'h9F, 8'h01, 8'h82,
            8'h00, 8'h02, 8'hAA, 8'hBB, 8'h9E, 8'h00, 8'h9F, 8'h7F, 8'h00, 8'h76, 8'h03, 8'h81, 8'h01, 8'hCC,
            8'hC1, 8'h00, 8'hE2, 8'h00};
        repeat (8) @(posedge sys_clk_i);
        cmp_val({4'h0, 32'(src.q.size())}, 36'h2D);
        axi_write(CTRL_ADDR, 32'h1, RESP_OKAY);
        foreach (hx[i]) cmp_hdr(hx[i]);
        chk_rd(CLASS_ADDR, 32'h1417, RESP_OKAY);
        chk_rd(COUNT_ADDR, 32'h10, RESP_OKAY);
        // each malformed header latches the error until software clears it
        foreach (ex[i])
        begin
            rst_b_i <= 1'b0;
            repeat (2) @(posedge sys_clk_i);
            rst_b_i <= 1'b1;
            repeat (4) @(posedge sys_clk_i);
            if (ex[i][15:8] != 8'h00) src.q.push_back(ex[i][15:8]);
            src.q.push_back(ex[i][7:0]);
            for (int k = 0; k < 50 && hdr_err_o !== 1'b1; k++) @(posedge sys_clk_i);
            cmp_val({35'h0, hdr_err_o}, 36'h1);
            chk_rd(STATUS_ADDR, 32'h1, RESP_OKAY);
            if (i == 2) cmp_hdr(36'h005A00000);
            axi_write(CTRL_ADDR, 32'h3, RESP_OKAY);
            repeat (2) @(posedge sys_clk_i);
            cmp_val({35'h0, hdr_err_o}, 36'h0);
        end
        give_verdict();
    end
    initial
    begin
        #40000;
        fails++;
        give_verdict();
    end
endmodule

// ==== sim/byte_source.sv ====
/* byte source model standing in for the card interface or message buffer.
   assumes the decoder takes a byte at a rising edge with valid and ready high. */
`timescale 1ns/1ps
module byte_source (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // byte stream
    input wire logic ready_i,
    output logic valid_o = 1'b0,
    output logic [7:0] data_o = 8'h5A
);
    logic [7:0] q[$];
    int gap = 0;
    int idle = 0;
    // ------------------------------------------------------------
    // head byte held until taken, optional idle gap between bytes
    // ------------------------------------------------------------
    always @(posedge clk_i)
    begin
        if (valid_o === 1'b1 && ready_i === 1'b1)
        begin
            void'(q.pop_front());
            idle = gap;
        end
        else if (idle > 0)
            idle = idle - 1;
        valid_o <= rst_b_i && idle == 0 && q.size() > 0;
        // released line flips each cycle so a stale byte can never pass as fresh
        data_o <= (rst_b_i && idle == 0 && q.size() > 0) ? q[0] : ~data_o;
    end
endmodule

// ==== sim/tlv_header_decoder_chk.sv ====
/* port-level checks for the header decoder, bound onto its top module.
   assumes one clock; the asynchronous reset disables every check. */
`timescale 1ns/1ps
module tlv_header_decoder_chk
    import tlv_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // byte stream and header
    input wire logic byte_ready_o,
    input wire logic hdr_valid_o,
    input wire logic [15:0] hdr_tag_o,
    input wire logic [3:0] hdr_kind_o,
    input wire logic hdr_err_o,
    // register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    hdr_pulse_a: assert property (hdr_valid_o |=> !hdr_valid_o)
        else $error("header pulse longer than one cycle");
    header_gap_a: assert property (hdr_valid_o |-> !byte_ready_o)
        else $error("byte taken during header pulse");
    error_stall_a: assert property (hdr_err_o |-> !byte_ready_o)
        else $error("byte taken while error is set");
    iso_tmpl_a: assert property (hdr_valid_o && !hdr_err_o && (hdr_tag_o == TAG_APP_TMPL || hdr_tag_o == TAG_FCI_TMPL)
        |-> hdr_kind_o == KIND_ISO_TMPL) else $error("iso template misclassified");
    pay_tmpl_a: assert property (hdr_valid_o && !hdr_err_o && hdr_tag_o inside {[TAG_PAY_LO:TAG_PAY_HI]}
        |-> hdr_kind_o == KIND_PAY_TMPL) else $error("payment template misclassified");
    issuer_obj_a: assert property (hdr_valid_o && !hdr_err_o && hdr_tag_o[15:6] == 10'h003
        |-> hdr_kind_o == KIND_ISSUER) else $error("private object not issuer defined");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read answer late");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
    cover property (hdr_valid_o && hdr_kind_o == KIND_POOL);
    cover property ($rose(hdr_err_o));
    cover property (hdr_valid_o && hdr_kind_o == KIND_MISPLACED);
endmodule
bind tlv_header_decoder tlv_header_decoder_chk chk (.sys_clk_i, .rst_b_i, .byte_ready_o, .hdr_valid_o,
    .hdr_tag_o, .hdr_kind_o, .hdr_err_o, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
